// *** design/dtm_decoder.sv ***
// Terminal input decoder for fan/pump and process control modes
`timescale 1ns/1ps
module dtm_decoder (
  // Clock, reset, enable
  input  wire logic                            core_clk_in,
  input  wire logic                            rst_b_in,
  input  wire logic                            clk_en_in,
  // Isolated terminal lines, high means closed
  input  wire logic [dtm_pkg::DTM_NUM_LINES-1:0] opto_line_in,
  // Configuration
  input  wire dtm_pkg::dtm_mode_t              operating_mode_setting_in,
  input  wire logic                            cmdsrc_is_analog1_in,
  input  wire logic                            ext_trip_enable_in,
  input  wire logic                            vector_control_in,
  // Keypad commands
  input  wire logic                            key_start_fwd_in,
  input  wire logic                            key_start_rev_in,
  input  wire logic                            key_stop_in,
  input  wire logic                            key_reset_in,
  // Demand from the speed source
  input  wire logic                            cmd_dir_rev_in,
  input  wire logic                            cmd_nonzero_in,
  // Decoded commands
  output logic                                 control_enable_out,
  output logic                                 run_fwd_out,
  output logic                                 run_rev_out,
  output logic                                 coast_stop_out,
  output logic                                 decel_stop_out,
  output logic                                 zero_current_stop_out,
  output logic                                 fault_reset_out,
  output logic                                 ext_trip_out,
  output dtm_pkg::dtm_spd_t                    speed_sel_out,
  output logic                                 keypad_cmd_out,
  output logic                                 param_table2_out,
  output logic                                 accel_group2_out,
  output logic                                 torque_mode_out,
  output logic                                 pid_enable_out,
  output logic                                 pid_int_clear_out,
  output logic                                 jog_out
);
  import dtm_pkg::*;

  logic [DTM_NUM_LINES-1:0] sync1_r;
  logic [DTM_NUM_LINES-1:0] sync2_r;
  logic [DTM_NUM_LINES-1:0] line_r;
  logic [DTM_NUM_LINES-1:0] line_prev_r;
  dtm_state_t               state_r;
  dtm_state_t               state_nxt;
  logic                     stop_r;

  // R23 two-flop synchroniser
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      sync1_r <= DTM_LINES_RST;
      sync2_r <= DTM_LINES_RST;
    end else if (clk_en_in) begin
      sync1_r <= opto_line_in;
      sync2_r <= sync1_r;
    end
  end

  // R23 per-line debounce filter
  genvar gi;
  generate
    for (gi = 0; gi < DTM_NUM_LINES; gi++) begin : g_db
      logic [DTM_DB_W-1:0] cnt_r;
      logic                lvl_r;
      assign line_r[gi] = lvl_r;
      always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
          cnt_r <= '0;
          lvl_r <= DTM_LINES_RST[gi];
        end else if (clk_en_in) begin
          if (sync2_r[gi] == lvl_r) begin
            cnt_r <= '0;
          end else if (cnt_r == DTM_DB_MAX) begin
            cnt_r <= '0;
            lvl_r <= sync2_r[gi];
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      line_prev_r <= DTM_LINES_RST;
    end else if (clk_en_in) begin
      line_prev_r <= line_r;
    end
  end

  wire la = line_r[DTM_LINE_A];
  wire lb = line_r[DTM_LINE_B];
  wire lc = line_r[DTM_LINE_C];
  wire ld = line_r[DTM_LINE_D];
  wire le = line_r[DTM_LINE_E];
  wire lf = line_r[DTM_LINE_F];
  wire lg = line_r[DTM_LINE_G];
  wire lh = line_r[DTM_LINE_H];
  wire li = line_r[DTM_LINE_I];
  wire b_rise = lb & ~line_prev_r[DTM_LINE_B];
  wire c_rise = lc & ~line_prev_r[DTM_LINE_C];
  wire d_fall = ~ld & line_prev_r[DTM_LINE_D];

  wire is_fp   = (operating_mode_setting_in != DTM_MODE_PROC);
  wire is_fp3  = (operating_mode_setting_in == DTM_MODE_FP3);
  wire is_proc = (operating_mode_setting_in == DTM_MODE_PROC);
  // R8 terminal or keypad command source
  wire term_cmd = le;
  wire both_bc  = lb & lc;

  // Fan/pump speed table; used only in fan/pump modes
  function automatic dtm_spd_t fp_speed(input logic f, input logic g, input logic h,
                                        input logic d, input logic two_wire, input logic src_an1);
    // R10 preset 1 when g open
    if (!g) begin
      fp_speed = DTM_SPD_PRESET1;
    // R11 preset 2 when h open
    end else if (!h) begin
      fp_speed = DTM_SPD_PRESET2;
    // R12 keypad speed when f open
    end else if (!f) begin
      fp_speed = DTM_SPD_KEYPAD;
    // R13 analog 1 override in two-wire
    end else if ((two_wire && d) || src_an1) begin
      fp_speed = DTM_SPD_ANALOG1;
    end else begin
      fp_speed = DTM_SPD_CMDSRC;
    end
  endfunction : fp_speed

  // Torque mode: process control, vector control, line e closed
  function automatic logic torque_sel(input logic proc, input logic vec, input logic e);
    torque_sel = proc && vec && e;
  endfunction : torque_sel

  // Motion state next value
  always_comb begin
    state_nxt = state_r;
    if (is_proc) begin
      // R14 independent direction enables
      if (cmd_dir_rev_in) begin
        state_nxt = lc ? DTM_ST_REV : DTM_ST_IDLE;
      end else begin
        state_nxt = lb ? DTM_ST_FWD : DTM_ST_IDLE;
      end
      // R15 both enables open stops
      if (!lb && !lc) begin
        state_nxt = DTM_ST_IDLE;
      end
      // R21 fault reset blocks running
      if (lh) begin
        state_nxt = DTM_ST_IDLE;
      end
    end else if (term_cmd) begin
      if (!is_fp3) begin
        // R2 R3 R4 two-wire levels
        case ({lb, lc})
          2'b10:   state_nxt = DTM_ST_FWD;
          2'b01:   state_nxt = DTM_ST_REV;
          default: state_nxt = DTM_ST_IDLE;
        endcase
      end else begin
        // R5 momentary start latches
        if (both_bc) begin
          state_nxt = state_r;
        end else if (b_rise) begin
          state_nxt = DTM_ST_FWD;
        end else if (c_rise) begin
          state_nxt = DTM_ST_REV;
        end
        // R6 momentary opening stops
        if (d_fall || !ld) begin
          state_nxt = DTM_ST_IDLE;
        end
      end
    end else begin
      // R9 keypad keeps present motion until keyed
      if (key_stop_in) begin
        state_nxt = DTM_ST_IDLE;
      end else if (key_start_fwd_in) begin
        state_nxt = DTM_ST_FWD;
      end else if (key_start_rev_in) begin
        state_nxt = DTM_ST_REV;
      end
    end
    // R1 control disabled clears motion
    if (!la) begin
      state_nxt = DTM_ST_IDLE;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      state_r <= DTM_ST_IDLE;
    end else if (clk_en_in) begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      stop_r <= 1'b0;
    end else if (clk_en_in) begin
      // R2 R3 R6 R14 run end or reversal decels
      stop_r <= (state_nxt != state_r) && (state_r != DTM_ST_IDLE) && la;
    end
  end

  // Registered enable, coast and run outputs
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      control_enable_out <= 1'b0;
      coast_stop_out     <= 1'b1;
      run_fwd_out        <= 1'b0;
      run_rev_out        <= 1'b0;
    end else if (clk_en_in) begin
      // R1 enable and coast
      control_enable_out <= la;
      coast_stop_out     <= ~la;
      run_fwd_out        <= (state_nxt == DTM_ST_FWD);
      run_rev_out        <= (state_nxt == DTM_ST_REV);
    end
  end

  // Stop pulse, split by speed or torque mode
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      decel_stop_out        <= 1'b0;
      zero_current_stop_out <= 1'b0;
    end else if (clk_en_in) begin
      // R18 torque-mode stop is zero current
      decel_stop_out        <= stop_r && !torque_sel(is_proc, vector_control_in, le);
      zero_current_stop_out <= stop_r && torque_sel(is_proc, vector_control_in, le);
    end
  end

  // Fault reset and external trip
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      fault_reset_out <= 1'b0;
      ext_trip_out    <= 1'b0;
    end else if (clk_en_in) begin
      // R4 R7 R21 fault reset decode
      if (is_proc) begin
        fault_reset_out <= lh;
      end else if (term_cmd) begin
        fault_reset_out <= both_bc;
      end else begin
        fault_reset_out <= key_reset_in;
      end
      // R22 external trip when enabled
      ext_trip_out <= ext_trip_enable_in & ~li;
    end
  end

  // Jog request
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      jog_out <= 1'b0;
    end else if (clk_en_in) begin
      // R20 jog only in enabled direction
      jog_out <= is_proc && lg && (cmd_dir_rev_in ? lc : lb) && la;
    end
  end

  // Speed source and command source outputs
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      speed_sel_out  <= DTM_SPD_PRESET1;
      keypad_cmd_out <= 1'b1;
    end else if (clk_en_in) begin
      speed_sel_out  <= is_proc ? DTM_SPD_CMDSRC : fp_speed(lf, lg, lh, ld, !is_fp3, cmdsrc_is_analog1_in);
      keypad_cmd_out <= is_fp && !term_cmd;
    end
  end

  // Process control selections
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      param_table2_out  <= 1'b0;
      accel_group2_out  <= 1'b0;
      torque_mode_out   <= 1'b0;
      pid_enable_out    <= 1'b0;
      pid_int_clear_out <= 1'b1;
    end else if (clk_en_in) begin
      // R16 parameter table select
      param_table2_out  <= is_proc && ld;
      // R17 group or torque mode
      accel_group2_out  <= is_proc && le && !vector_control_in;
      torque_mode_out   <= torque_sel(is_proc, vector_control_in, le);
      // R19 PID enable and integrator clear
      pid_enable_out    <= is_proc && lf;
      pid_int_clear_out <= !(is_proc && lf);
    end
  end
endmodule : dtm_decoder

// *** design/dtm_pkg.sv ***
// Constants and types for the drive terminal mode decoder
// Contract
// R1: Line a open disables control, coast stop
// R2: Two-wire: b alone runs forward
// R3: Two-wire: c alone runs reverse
// R4: Two-wire: b and c together reset fault
// R5: Three-wire: momentary b/c starts, latches run
// R6: Three-wire: momentary d opening stops run
// R7: Three-wire: b and c together reset fault
// R8: Line e picks terminal or keypad commands
// R9: Keep speed and direction across switchover
// R10: Line g open selects preset speed 1
// R11: G closed, h open selects preset 2
// R12: F open, g h closed: keypad speed
// R13: All closed: command source, or analog 1
// R14: Process: b/c enable forward/reverse independently
// R15: Process: b and c open stops
// R16: Process: line d picks parameter table
// R17: Process: line e picks group/torque mode
// R18: Torque-mode stop drives zero current
// R19: Process: line f enables PID, else clears
// R20: Process: jog only in enabled direction
// R21: Process: line h closed resets fault
// R22: Line i open raises external trip
// R23: Synchronise and debounce every input; code filters only opto_line_in, other inputs used directly
package dtm_pkg;
  // Operating modes
  typedef enum logic [1:0] {
    DTM_MODE_FP2  = 2'h0,
    DTM_MODE_FP3  = 2'h1,
    DTM_MODE_PROC = 2'h3
  } dtm_mode_t;

  // Speed command source selection
  typedef enum logic [2:0] {
    DTM_SPD_PRESET1 = 3'h0,
    DTM_SPD_PRESET2 = 3'h1,
    DTM_SPD_KEYPAD  = 3'h2,
    DTM_SPD_CMDSRC  = 3'h3,
    DTM_SPD_ANALOG1 = 3'h4
  } dtm_spd_t;

  // Motion state of the three-wire latch and run output
  typedef enum logic [1:0] {
    DTM_ST_IDLE = 2'h0,
    DTM_ST_FWD  = 2'h1,
    DTM_ST_REV  = 2'h3
  } dtm_state_t;

  localparam int unsigned DTM_NUM_LINES = 9;
  localparam int unsigned DTM_LINE_A    = 0;
  localparam int unsigned DTM_LINE_B    = 1;
  localparam int unsigned DTM_LINE_C    = 2;
  localparam int unsigned DTM_LINE_D    = 3;
  localparam int unsigned DTM_LINE_E    = 4;
  localparam int unsigned DTM_LINE_F    = 5;
  localparam int unsigned DTM_LINE_G    = 6;
  localparam int unsigned DTM_LINE_H    = 7;
  localparam int unsigned DTM_LINE_I    = 8;

  // Contact bounce settling time and its cycle count at 100 MHz
  localparam int unsigned DTM_CLK_MHZ      = 100;
  localparam int unsigned DTM_DEBOUNCE_US  = 20;
  localparam int unsigned DTM_DEBOUNCE_CYC = DTM_DEBOUNCE_US * DTM_CLK_MHZ;
  localparam int unsigned DTM_DB_W         = 12;
  localparam logic [DTM_DB_W-1:0] DTM_DB_MAX = DTM_DB_W'(DTM_DEBOUNCE_CYC - 1);

  // Reset value of the filtered lines: all open
  localparam logic [DTM_NUM_LINES-1:0] DTM_LINES_RST = 9'h000;
endpackage : dtm_pkg

// *** verif/dtm_decoder_properties.sv ***
// Concurrent checks on the decoder ports
`timescale 1ns/1ps
module dtm_decoder_properties (
  // Clock and reset
  input wire logic                              core_clk_in,
  input wire logic                              rst_b_in,
  // Watched inputs
  input wire logic [dtm_pkg::DTM_NUM_LINES-1:0] opto_line_in,
  input wire dtm_pkg::dtm_mode_t                operating_mode_setting_in,
  input wire logic                              ext_trip_enable_in,
  input wire logic                              vector_control_in,
  // Watched outputs
  input wire logic                              control_enable_out,
  input wire logic                              coast_stop_out,
  input wire logic                              run_fwd_out,
  input wire logic                              run_rev_out,
  input wire logic                              decel_stop_out,
  input wire logic                              zero_current_stop_out,
  input wire logic                              ext_trip_out,
  input wire logic                              torque_mode_out,
  input wire logic                              accel_group2_out
);
  import dtm_pkg::*;
  logic [11:0] quiet_r;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  // Cycles since line a last moved
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in || $changed(opto_line_in[DTM_LINE_A])) quiet_r <= 12'h000;
    else if (quiet_r != 12'hfff) quiet_r <= quiet_r + 12'h001;
  end
  property p_coast; control_enable_out != coast_stop_out; endproperty
  a_coast: assert property (p_coast) else $error("coast stop not inverse of enable");
  property p_filter; $changed(control_enable_out) |-> quiet_r > DTM_DB_MAX; endproperty
  a_filter: assert property (p_filter) else $error("enable moved before line a settled");
  property p_both; !(run_fwd_out && run_rev_out); endproperty
  a_both: assert property (p_both) else $error("forward and reverse run together");
  property p_trip; ext_trip_out |-> $past(ext_trip_enable_in); endproperty
  a_trip: assert property (p_trip) else $error("trip raised while disabled");
  property p_torq;
    torque_mode_out |-> $past(vector_control_in) && $past(operating_mode_setting_in) == DTM_MODE_PROC;
  endproperty
  a_torq: assert property (p_torq) else $error("torque mode outside vector process");
  property p_acc; accel_group2_out |-> !$past(vector_control_in); endproperty
  a_acc: assert property (p_acc) else $error("group 2 under vector control");
  property p_stop;
    ($fell(run_fwd_out) || $fell(run_rev_out)) && control_enable_out |-> ##[0:2]
      (decel_stop_out || zero_current_stop_out);
  endproperty
  a_stop: assert property (p_stop) else $error("run ended without stop pulse");
  property p_pulse; decel_stop_out |=> !decel_stop_out; endproperty
  a_pulse: assert property (p_pulse) else $error("decel stop longer than a cycle");
endmodule : dtm_decoder_properties

// *** verif/dtm_decoder_test.sv ***
// Self-checking bench for the terminal mode decoder
`timescale 1ns/1ps
`define CHK(n, x, y) begin comparisons++; if ((y) !== (x)) begin mismatches++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, x, y); end end
module dtm_decoder_test;
  import dtm_pkg::*;
  logic        core_clk_in = 1'b0;
  logic        rst_b_in    = 1'b0;
  logic [8:0]  want        = 9'h000;
  logic [8:0]  lines;
  dtm_mode_t   mode        = DTM_MODE_FP2;
  logic        an1 = 1'b0, ext_en = 1'b0, vec = 1'b0, dir = 1'b0, nz = 1'b0, ks = 1'b0, pb = 1'b0, pcl = 1'b0;
  logic        kf = 1'b0, kr = 1'b0, krs = 1'b0, en = 1'b1;
  logic        ce, rf, rr, cs, ds, zs, fr, et, kp, pt, ag, tq, pe, pc, jg;
  dtm_spd_t    sp;
  int          mismatches = 0, comparisons = 0, seed = 32'hffd50e63, st = 0;
  logic [10:0] t1 [10] = '{11'h1f3, 11'h1f5, 11'h1f7, 11'h1f9, 11'h1b9, 11'h179, 11'h1d9, 11'h0f3, 11'h1e3, 11'h1e1};
  logic [10:0] t2 [15] = '{11'h1f0, 11'h1f9, 11'h3f9, 11'h3fb, 11'h3f9, 11'h3f1, 11'h3f9, 11'h3fd, 11'h3f9,
                           11'h3fd, 11'h3ff, 11'h7f3, 11'h773, 11'h707, 11'h731};
  always #5 core_clk_in = ~core_clk_in;
  dtm_switch_model sw (.clk_in(core_clk_in), .want_in(want), .line_out(lines));
  dtm_decoder dut (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .clk_en_in(en), .opto_line_in(lines),
    .operating_mode_setting_in(mode), .cmdsrc_is_analog1_in(an1), .ext_trip_enable_in(ext_en),
    .vector_control_in(vec), .key_start_fwd_in(kf), .key_start_rev_in(kr), .key_stop_in(ks),
    .key_reset_in(krs), .cmd_dir_rev_in(dir), .cmd_nonzero_in(nz), .control_enable_out(ce),
    .run_fwd_out(rf), .run_rev_out(rr), .coast_stop_out(cs), .decel_stop_out(ds),
    .zero_current_stop_out(zs), .fault_reset_out(fr), .ext_trip_out(et), .speed_sel_out(sp),
    .keypad_cmd_out(kp), .param_table2_out(pt), .accel_group2_out(ag), .torque_mode_out(tq),
    .pid_enable_out(pe), .pid_int_clear_out(pc), .jog_out(jg));
  task automatic print_verdict;
    if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // Apply switch positions, let them settle, compare with the model
  task automatic step(input logic [8:0] l, input dtm_mode_t m);
    logic       b, c, d, e, f, g, h, p;
    logic [2:0] s;
    @(negedge core_clk_in);
    want = l;
    mode = m;
    {an1, ext_en, vec, dir, nz} = 5'($random(seed));
    repeat (2100) @(negedge core_clk_in);
    {h, g, f, e, d, c, b} = l[7:1];
    p = (m == DTM_MODE_PROC);
    if (p) st = (b && !dir && !h) ? 1 : (c && dir && !h) ? 2 : 0;
    else if (e && m != DTM_MODE_FP3) st = (b && !c) ? 1 : (c && !b) ? 2 : 0;
    else if (e) st = !d ? 0 : (b && !c && !pb) ? 1 : (c && !b && !pcl) ? 2 : st;
    pb = b;
    pcl = c;
    s = p ? 3'h3 : !g ? 3'h0 : !h ? 3'h1 : !f ? 3'h2 : (an1 || (d && m != DTM_MODE_FP3)) ? 3'h4 : 3'h3;
    `CHK("enable", l[0], ce)
    `CHK("coast", !l[0], cs)
    `CHK("trip", ext_en && !l[8], et)
    `CHK("speed", s, sp)
    `CHK("reset", p ? h : (e && b && c), fr)
    if (l[0]) begin
      `CHK("fwd", st == 1, rf)
      `CHK("rev", st == 2, rr)
    end
    if (p) begin
      `CHK("table2", d, pt)
      `CHK("accel2", e && !vec, ag)
      `CHK("torque", e && vec, tq)
      `CHK("pid", f, pe)
      `CHK("pid_clear", !f, pc)
      `CHK("jog", g && (dir ? c : b), jg)
    end
    else `CHK("keypad", !e, kp)
  endtask : step
  initial begin
    repeat (12) @(posedge core_clk_in);
    @(negedge core_clk_in) rst_b_in = 1'b1;
    foreach (t1[i]) step(t1[i][8:0], dtm_mode_t'(t1[i][10:9]));
    @(negedge core_clk_in) ks = 1'b1;
    @(negedge core_clk_in) ks = 1'b0;
    repeat (3) @(negedge core_clk_in);
    st = 0;
    `CHK("key_stop", 1'b0, rf)
    // Key start while the clock enable is low must not act
    @(negedge core_clk_in) {en, kf} = 2'h1;
    repeat (3) @(negedge core_clk_in);
    `CHK("freeze", 1'b0, rf)
    en = 1'b1;
    @(negedge core_clk_in) kf = 1'b0;
    repeat (3) @(negedge core_clk_in);
    `CHK("key_fwd", 1'b1, rf)
    @(negedge core_clk_in) {kr, krs} = 2'h3;
    repeat (3) @(negedge core_clk_in);
    `CHK("key_rev", 1'b1, rr)
    `CHK("key_reset", 1'b1, fr)
    {kr, krs} = 2'h0;
    st = 2;
    foreach (t2[i]) step(t2[i][8:0], dtm_mode_t'(t2[i][10:9]));
    repeat (6) step(9'($random(seed)) | 9'h001, DTM_MODE_PROC);
    step(9'h1fb, dtm_mode_t'(2'h2));
    print_verdict();
  end
  initial begin
    repeat (75000) @(posedge core_clk_in);
    mismatches++;
    print_verdict();
  end
endmodule : dtm_decoder_test
bind dtm_decoder dtm_decoder_properties u_props (
  .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .opto_line_in(opto_line_in),
  .operating_mode_setting_in(operating_mode_setting_in), .ext_trip_enable_in(ext_trip_enable_in),
  .vector_control_in(vector_control_in), .control_enable_out(control_enable_out),
  .coast_stop_out(coast_stop_out), .run_fwd_out(run_fwd_out), .run_rev_out(run_rev_out),
  .decel_stop_out(decel_stop_out), .zero_current_stop_out(zero_current_stop_out),
  .ext_trip_out(ext_trip_out), .torque_mode_out(torque_mode_out), .accel_group2_out(accel_group2_out));

// *** verif/dtm_switch_model.sv ***
// Model of the switch bank that drives the terminal lines
`timescale 1ns/1ps
module dtm_switch_model (
  // Clock and wanted switch positions
  input  wire logic       clk_in,
  input  wire logic [8:0] want_in,
  // Terminal lines, high means closed
  output logic      [8:0] line_out
);
  int         seed = 32'hffd50e63;
  int         n    = 0;
  logic [8:0] m    = 9'h000;
  initial line_out = 9'h000;
  // Moving contacts chatter briefly, far below the filter time
  always @(negedge clk_in) begin
    if (n == 0 && want_in !== line_out) begin
      n = 40;
      m = want_in ^ line_out;
    end
    if (n > 0) begin
      n = n - 1;
      line_out = (n == 0) ? want_in : want_in ^ (m & 9'($random(seed)));
    end
  end
endmodule : dtm_switch_model
